// *** rtl/cdi_pkg.sv ***
// Package: register map, field positions and reset values of the CPU-domain idle block
package cdi_pkg;
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 16;
	localparam logic [15:0] CONFIG_OFFSET    = 16'h0001;
	localparam logic [15:0] MIRROR_OFFSET    = 16'h0002;
	localparam logic [15:0] CONFIG_RESET     = 16'h0000;
	localparam logic [15:0] MIRROR_RESET     = 16'h0000;
	localparam int          ACCEL_BIT        = 9;
	localparam int          FETCH_BIT        = 8;
	localparam int          MEM_BIT          = 7;
	localparam int          IO_BIT           = 6;
	localparam int          DATA_BIT         = 5;
	localparam int          CORE_BIT         = 0;
	localparam int          PATTERN_LSB      = 1;
	localparam int          PATTERN_MSB      = 4;
	localparam logic [3:0]  PATTERN_VALUE    = 4'h7;
	// Only these bits exist; the rest read as zero
	localparam logic [15:0] CONFIG_MASK      = 16'h03FF;
	localparam logic [15:0] MIRROR_MASK      = 16'h03E1;
	// Bits that an unmasked interrupt clears on wake-up
	localparam logic [15:0] WAKE_CLEAR_MASK  = 16'h0161;
	localparam logic [15:0] PORT_BITS_MASK   = 16'h01E0;
	localparam logic [15:0] CPU_PORT_MASK    = 16'h0160;
endpackage : cdi_pkg

// *** rtl/cdi_idle_ctrl.sv ***
// CPU-domain idle configuration, idle status mirror and clock-gate drive
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
// How it works
// - Config bit 9 idles the accelerator
// - Config bit 8 idles the fetch port
// - Config bit 7 idles the memory port
// - Config bit 6 idles the I/O port
// - Config bit 5 idles the data port
// - Config bit 0 idles the core
// - Status bit 9 shows accelerator stopped
// - Status bit 8 shows fetch port off
// - Status bit 7 shows memory port off
// - Status bit 6 shows I/O port off
// - Status bit 5 shows data port off
// - Status read-only, resets zero, reserved zero
// - Idle instruction copies config into status
// - Interrupt clears bits 0,5,6,8 immediately
// - Invalid idle raises fault, status unchanged
module cdi_idle_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        idle_exec,
	input  wire logic        wake_irq,
	output logic             bus_fault_flag,
	output logic             core_clk_stop,
	output logic             fetch_port_clk_stop,
	output logic             mem_port_clk_stop,
	output logic             io_port_clk_stop,
	output logic             data_port_clk_stop,
	output logic             accel_clk_stop
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [15:0] idle_request_config_r;
	logic [15:0] idle_request_config_nxt;
	logic [15:0] idle_state_mirror_r;
	logic [15:0] idle_state_mirror_nxt;
	logic [15:0] reg_rdata_r;
	logic [15:0] reg_rdata_nxt;
	logic        bus_fault_flag_r;
	logic        bus_fault_flag_nxt;
	logic        idle_valid;
	logic        idle_bad;
	logic        cfg_wr_hit;
	logic        mirror_rd_hit;
	logic        pattern_ok;
	logic        port_req;
	logic        cpu_port_req;
	logic [3:0]  sleep_pattern_field;
	logic [15:0] mirror_live;

	assign sleep_pattern_field = idle_request_config_r[cdi_pkg::PATTERN_MSB:cdi_pkg::PATTERN_LSB];
	assign cfg_wr_hit          = reg_wr && (reg_addr == cdi_pkg::CONFIG_OFFSET);
	assign mirror_rd_hit       = reg_rd && (reg_addr == cdi_pkg::MIRROR_OFFSET);

	// ----------------------------------------------------------------
	// Idle request validity
	// ----------------------------------------------------------------
	// Software is expected to hold the pattern; hardware only guards it
	// A bad idle is refused as a whole, so no port is left half gated
	always_comb begin
		pattern_ok   = (sleep_pattern_field == cdi_pkg::PATTERN_VALUE);
		port_req     = (idle_request_config_r & cdi_pkg::PORT_BITS_MASK) != 16'h0000;
		cpu_port_req = (idle_request_config_r & cdi_pkg::CPU_PORT_MASK) != 16'h0000;
		idle_valid   = 1'b1;
		if (port_req && !pattern_ok) begin
			idle_valid = 1'b0;
		end
		if (cpu_port_req && !idle_request_config_r[cdi_pkg::CORE_BIT]) begin
			idle_valid = 1'b0;
		end
		idle_bad     = idle_exec && !idle_valid;
	end

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	// Stored only; the gates never look at this register
	always_comb begin
		idle_request_config_nxt = idle_request_config_r;
		if (cfg_wr_hit) begin
			idle_request_config_nxt = reg_wdata & cdi_pkg::CONFIG_MASK;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle_request_config_r <= cdi_pkg::CONFIG_RESET;
		end else if (clk_en) begin
			idle_request_config_r <= idle_request_config_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Idle status mirror
	// ----------------------------------------------------------------
	// No write path: the mirror is read-only
	// Idle and wake together: copy first, then the wake clear
	always_comb begin
		idle_state_mirror_nxt = idle_state_mirror_r;
		if (idle_exec && idle_valid) begin
			idle_state_mirror_nxt = idle_request_config_r & cdi_pkg::MIRROR_MASK;
		end
		// Memory port and accelerator stay stopped on wake
		if (wake_irq) begin
			idle_state_mirror_nxt = idle_state_mirror_nxt & ~cdi_pkg::WAKE_CLEAR_MASK;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idle_state_mirror_r <= cdi_pkg::MIRROR_RESET;
		end else if (clk_en) begin
			idle_state_mirror_r <= idle_state_mirror_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Bus fault flag
	// ----------------------------------------------------------------
	// A new fault in the cycle of a status read wins over the clear
	always_comb begin
		bus_fault_flag_nxt = bus_fault_flag_r;
		if (mirror_rd_hit) begin
			bus_fault_flag_nxt = 1'b0;
		end
		if (idle_bad) begin
			bus_fault_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_fault_flag_r <= 1'b0;
		end else if (clk_en) begin
			bus_fault_flag_r <= bus_fault_flag_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	// Data stand one cycle after the strobe, zero otherwise
	always_comb begin
		reg_rdata_nxt = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				cdi_pkg::CONFIG_OFFSET: reg_rdata_nxt = idle_request_config_r;
				cdi_pkg::MIRROR_OFFSET: reg_rdata_nxt = mirror_live;
				default:                reg_rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata_r <= reg_rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Clock-gate drive
	// ----------------------------------------------------------------
	// Wake acts without a clock edge, since the core clock itself is stopped
	assign mirror_live = wake_irq ? (idle_state_mirror_r & ~cdi_pkg::WAKE_CLEAR_MASK) : idle_state_mirror_r;

	assign accel_clk_stop      = mirror_live[cdi_pkg::ACCEL_BIT];
	assign fetch_port_clk_stop = mirror_live[cdi_pkg::FETCH_BIT];
	assign mem_port_clk_stop   = mirror_live[cdi_pkg::MEM_BIT];
	assign io_port_clk_stop    = mirror_live[cdi_pkg::IO_BIT];
	assign data_port_clk_stop  = mirror_live[cdi_pkg::DATA_BIT];
	assign core_clk_stop       = mirror_live[cdi_pkg::CORE_BIT];
	assign reg_rdata           = reg_rdata_r;
	assign bus_fault_flag      = bus_fault_flag_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Named steps of an idle request and a status read
	sequence s_valid_idle;
		clk_en && idle_exec && idle_valid && !wake_irq;
	endsequence

	sequence s_status_read;
		clk_en && reg_rd && reg_addr == cdi_pkg::MIRROR_OFFSET;
	endsequence

	// ----------------------------------------------------------------
	// Idle copy, refusal, wake, status read and accelerator gate
	// ----------------------------------------------------------------
	a_idle_copy: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> idle_state_mirror_r == ($past(idle_request_config_r) & cdi_pkg::MIRROR_MASK))
		else $error("status not copied from config on idle");
	a_bad_idle_hold: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && idle_exec && !idle_valid && !wake_irq |=> $stable(idle_state_mirror_r) && bus_fault_flag)
		else $error("invalid idle changed status or no fault");
	a_write_no_gate: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && !idle_exec && !wake_irq |=> $stable(idle_state_mirror_r))
		else $error("config write moved the gates");
	a_wake_clears: assert property (@(posedge ref_clk) disable iff (rst)
		wake_irq |-> !core_clk_stop && !data_port_clk_stop && !io_port_clk_stop && !fetch_port_clk_stop)
		else $error("wake did not release ports");
	a_wake_keeps_mem: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wake_irq && !idle_exec |=> $stable(idle_state_mirror_r[cdi_pkg::MEM_BIT]) &&
			$stable(idle_state_mirror_r[cdi_pkg::ACCEL_BIT]))
		else $error("wake released memory port or accelerator");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(idle_state_mirror_r & ~cdi_pkg::MIRROR_MASK) == 16'h0000)
		else $error("reserved status bits set");
	a_read_mirror: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == cdi_pkg::MIRROR_OFFSET |=> reg_rdata == $past(mirror_live))
		else $error("status read data wrong");
	a_accel_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> accel_clk_stop == $past(idle_request_config_r[cdi_pkg::ACCEL_BIT]))
		else $error("accelerator gate mismatch");

	// ----------------------------------------------------------------
	// Port and core gates
	// ----------------------------------------------------------------
	a_fetch_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> wake_irq || fetch_port_clk_stop == $past(idle_request_config_r[cdi_pkg::FETCH_BIT]))
		else $error("fetch port gate mismatch");

	a_io_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> wake_irq || io_port_clk_stop == $past(idle_request_config_r[cdi_pkg::IO_BIT]))
		else $error("io port gate mismatch");

	a_data_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> wake_irq || data_port_clk_stop == $past(idle_request_config_r[cdi_pkg::DATA_BIT]))
		else $error("data port gate mismatch");

	a_core_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> wake_irq || core_clk_stop == $past(idle_request_config_r[cdi_pkg::CORE_BIT]))
		else $error("core gate mismatch");

	// ----------------------------------------------------------------
	// Fault flag, register bus, clock-enable freeze and memory port gate
	// ----------------------------------------------------------------
	a_fault_clear: assert property (@(posedge ref_clk) disable iff (rst)
		s_status_read and !idle_exec |=> !bus_fault_flag)
		else $error("status read did not clear fault");

	a_fault_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && bus_fault_flag && !mirror_rd_hit |=> bus_fault_flag)
		else $error("fault flag dropped without status read");

	a_read_config: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == cdi_pkg::CONFIG_OFFSET |=> reg_rdata == $past(idle_request_config_r))
		else $error("config read data wrong");

	a_read_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");

	a_config_reserved: assert property (@(posedge ref_clk) disable iff (rst)
		(idle_request_config_r & ~cdi_pkg::CONFIG_MASK) == 16'h0000)
		else $error("reserved config bits set");

	a_freeze_state: assert property (@(posedge ref_clk) disable iff (rst)
		!clk_en |=> $stable(idle_request_config_r) && $stable(idle_state_mirror_r) && $stable(bus_fault_flag))
		else $error("state moved while clock enable low");
	a_mem_gate: assert property (@(posedge ref_clk) disable iff (rst)
		s_valid_idle |=> mem_port_clk_stop == $past(idle_request_config_r[cdi_pkg::MEM_BIT]))
		else $error("memory port gate mismatch");

endmodule : cdi_idle_ctrl

// *** verif/cdi_cpu_model.sv ***
// CPU core model: issues idle instructions and interrupt wake-ups
`timescale 1ns/1ns
module cdi_cpu_model (
	input  wire logic ref_clk,
	output logic      idle_exec,
	output logic      wake_irq
);
	initial begin
		idle_exec = 1'b0;
		wake_irq  = 1'b0;
	end
	// Idle stands alone, one cycle; callers load the config first, an illegal pattern in the fault test
	task automatic do_idle();
		@(posedge ref_clk);
		idle_exec <= 1'b1;
		@(posedge ref_clk);
		idle_exec <= 1'b0;
		#1;
	endtask : do_idle
	task automatic set_wake(input logic lvl);
		@(posedge ref_clk);
		wake_irq <= lvl;
		#1;
	endtask : set_wake
endmodule : cdi_cpu_model

// *** verif/test_cdi_idle_ctrl.sv ***
// Self-checking bench for the CPU-domain idle block
`timescale 1ns/1ns
module test_cdi_idle_ctrl;
	logic        ref_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [15:0] reg_addr  = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        clk_en    = 1'b1;
	logic [15:0] reg_rdata;
	logic        idle_exec;
	logic        wake_irq;
	logic        bus_fault_flag;
	logic [5:0]  stop;
	int          n_errors   = 0;
	int          n_compared = 0;
	always #10 ref_clk = ~ref_clk;
	cdi_cpu_model cdi_cpu_model_inst (.ref_clk(ref_clk), .idle_exec(idle_exec), .wake_irq(wake_irq));
	cdi_idle_ctrl cdi_idle_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.idle_exec(idle_exec), .wake_irq(wake_irq), .bus_fault_flag(bus_fault_flag),
		.core_clk_stop(stop[0]), .data_port_clk_stop(stop[1]), .io_port_clk_stop(stop[2]),
		.mem_port_clk_stop(stop[3]), .fetch_port_clk_stop(stop[4]), .accel_clk_stop(stop[5]));
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(what, exp, reg_rdata);
	endtask : rd_chk
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(16'h0002, 16'h0000, "status");
		rd_chk(16'h0001, 16'h0000, "config");
		$display("test reset done");
		wr(16'h0001, 16'h03EF);
		cmp("gates", 16'h0000, {10'h000, stop});
		cdi_cpu_model_inst.do_idle();
		cmp("gates", 16'h003F, {10'h000, stop});
		rd_chk(16'h0002, 16'h03E1, "status");
		$display("test full idle done");
		cdi_cpu_model_inst.set_wake(1'b1);
		cmp("gates", 16'h0028, {10'h000, stop});
		cdi_cpu_model_inst.set_wake(1'b0);
		rd_chk(16'h0002, 16'h0280, "status");
		$display("test wake done");
		wr(16'h0001, 16'h0021);
		cdi_cpu_model_inst.do_idle();
		cmp("fault", 16'h0001, {15'h0000, bus_fault_flag});
		cmp("gates", 16'h0028, {10'h000, stop});
		wr(16'h0002, 16'hFFFF);
		rd_chk(16'h0002, 16'h0280, "status");
		cmp("fault", 16'h0000, {15'h0000, bus_fault_flag});
		rd_chk(16'h0003, 16'h0000, "unmapped");
		$display("test fault done");
		wr(16'h0001, 16'hFC0E);
		rd_chk(16'h0001, 16'h000E, "config");
		cdi_cpu_model_inst.do_idle();
		rd_chk(16'h0002, 16'h0000, "status");
		wr(16'h0001, 16'h028E);
		cdi_cpu_model_inst.do_idle();
		cmp("gates", 16'h0028, {10'h000, stop});
		$display("test partial idle done");
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(16'h0001, 16'h03EF);
		cdi_cpu_model_inst.do_idle();
		cmp("frozen gates", 16'h0028, {10'h000, stop});
		@(posedge ref_clk);
		clk_en <= 1'b1;
		rd_chk(16'h0001, 16'h028E, "frozen config");
		$display("test clock enable done");
		finish_test();
	end
endmodule : test_cdi_idle_ctrl
